/* rfe_top.sv */
// rfe_top: resolver feedback configuration, wire break trip and simulated
// quadrature encoder output, with an apb register slave and interrupt.
// assumes position inputs are synchronous to pclk and change by small steps.
// Notes on behaviour
// (RULE1) electrical cycles per rev equals configured pole count divided by two
// (RULE2) pole count accepts only 2, 4, 6 or 8
// (RULE3) configurer sets pole count to motor poles unless resolver is 2-pole
// (RULE4) wire break check disabled means no broken-wire detection at all
// (RULE5) check enabled at reset; detected break raises drive trip
// (RULE6) output source defaults to slot resolver position parameter
// (RULE7) default source reproduces resolver position as quadrature output
// (RULE8) any 16-bit rollover counter source is accepted; code offers only NSRC table slots, picked by the low bits of src_id
// (RULE9) source ids accepted only from 00.00 up to 21.51
// (RULE10) source is multiplied by scale factor, default one
// (RULE11) 14-bit resolution quantizes factor to 1/32 up to 1
// (RULE12) 12-bit floors at 1/8, 10-bit at 1/2, above 0.5 gives 1
// (RULE13) line count is 256, 1024 or 4096 for 10, 12, 14 bits
// (RULE14) output gives four counts per equivalent line
// (RULE15) quadrature steps follow scaled counter changes, wrap is one step
module rfe_top
   import rfe_pkg::*;
#(
   parameter int NSRC = RFE_NSRC
)
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // feedback side
   input wire logic [15:0] res_pos,
   input wire logic wire_fault,
   input wire logic [16*NSRC-1:0] alt_pos,
   input wire logic [NSRC-1:0] alt_upd,
   // drive side
   output logic drive_trip,
   output logic [2:0] elec_cycles,
   output logic enc_a,
   output logic enc_b,
   output logic irq
);
   localparam int IW = $clog2(NSRC);

   // configuration registers
   logic [3:0] poles, next_poles;
   logic [1:0] lines, next_lines;
   logic wbd_en, next_wbd_en;
   logic [15:0] src_id, next_src_id;
   logic [15:0] num, next_num;
   logic [RFE_NEVT-1:0] stat, next_stat, mask, next_mask;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic [2:0] next_elec_cycles;
   logic next_drive_trip, next_irq;
   // position path
   logic [15:0] tbl_pos;
   logic [15:0] src_val, scaled, prev_scaled, next_prev_scaled;
   logic [15:0] cnt_pos, next_cnt_pos;
   logic [1:0] quad, next_quad;
   logic next_enc_a, next_enc_b;
   logic [4:0] shift_amt;
   logic [15:0] delta;
   logic wr, rd, cfg_err, trip_evt, use_res;

   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && penable && !pwrite && pready;

   // source table of alternate drive counters
   rfe_src_mem #(.DEPTH(NSRC)) u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(alt_upd),
      .wr_data(alt_pos),
      .rd_idx(src_id[IW-1:0]),
      .rd_data(tbl_pos)
   );

   // register write decode and validation
   always_comb
   begin
      next_poles = poles;
      next_lines = lines;
      next_wbd_en = wbd_en;
      next_src_id = src_id;
      next_num = num;
      next_mask = mask;
      cfg_err = 1'b0;
      if (wr)
      begin
         unique case (paddr)
            RFE_OFF_CFG:
            begin
               if (pwdata[RFE_CFG_POLES_LSB +: 4] inside
                  {4'h2, 4'h4, 4'h6, 4'h8}) // RULE2
                  next_poles = pwdata[RFE_CFG_POLES_LSB +: 4];
               else
                  cfg_err = 1'b1;
               if (pwdata[RFE_CFG_LINES_LSB +: 2] != 2'h3) // RULE13
                  next_lines = pwdata[RFE_CFG_LINES_LSB +: 2];
               else
                  cfg_err = 1'b1;
               next_wbd_en = pwdata[RFE_CFG_WBD_BIT];
            end
            RFE_OFF_SRC:
            begin
               // menu.parameter range check
               if (pwdata[15:8] <= RFE_SRC_MENU_MAX &&
                  pwdata[7:0] <= RFE_SRC_PAR_MAX) // RULE9
                  next_src_id = pwdata[15:0]; // RULE8
               else
                  cfg_err = 1'b1;
            end
            RFE_OFF_NUM:
            begin
               if (pwdata[15:0] <= RFE_NUM_MAX)
                  next_num = pwdata[15:0];
               else
                  cfg_err = 1'b1;
            end
            RFE_OFF_MASK: next_mask = pwdata[RFE_NEVT-1:0];
            default: ;
         endcase
      end
   end

   // config registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         poles <= RFE_POLES_RST;
         lines <= RFE_LINES_RST;
         wbd_en <= RFE_WBD_RST; // RULE5
         src_id <= RFE_SRC_RST; // RULE6
         num <= RFE_NUM_RST; // RULE10
         mask <= '0;
      end
      else
      begin
         poles <= next_poles;
         lines <= next_lines;
         wbd_en <= next_wbd_en;
         src_id <= next_src_id;
         num <= next_num;
         mask <= next_mask;
      end
   end

   // trip, status and read path; set beats the read-clear
   always_comb
   begin
      trip_evt = wbd_en && wire_fault; // RULE4 RULE5
      next_drive_trip = drive_trip || trip_evt; // latched until reset
      next_elec_cycles = 3'(poles >> 1); // RULE1
      next_stat = stat;
      // clear only what the read reported, so a bit set after setup survives
      if (rd && paddr == RFE_OFF_STAT)
         next_stat = stat & ~prdata[RFE_NEVT-1:0];
      if (trip_evt)
         next_stat[RFE_ST_TRIP] = 1'b1;
      if (cfg_err)
         next_stat[RFE_ST_CFGERR] = 1'b1;
      next_irq = |(next_stat & next_mask); // follows a mask write at once
      next_pready = psel && !penable; // one wait-free access phase
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (psel && !penable)
      begin
         unique case (paddr)
            RFE_OFF_CFG: next_prdata = {23'h0, wbd_en, 2'h0, lines, poles};
            RFE_OFF_SRC: next_prdata = {16'h0, src_id};
            RFE_OFF_NUM: next_prdata = {16'h0, num};
            RFE_OFF_POS: next_prdata = {16'h0, cnt_pos};
            RFE_OFF_STAT: next_prdata = {30'h0, stat};
            RFE_OFF_MASK: next_prdata = {30'h0, mask};
            RFE_OFF_INFO: next_prdata = {29'h0, elec_cycles};
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   // bus and event registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat <= '0;
         irq <= 1'b0;
         drive_trip <= 1'b0;
         elec_cycles <= 3'h1;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         stat <= next_stat;
         irq <= next_irq;
         drive_trip <= next_drive_trip;
         elec_cycles <= next_elec_cycles;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // scale quantization by resolution; shift is right shift of source
   always_comb
   begin
      use_res = (src_id == RFE_SRC_RST); // RULE7
      src_val = use_res ? res_pos : tbl_pos;
      if (num > RFE_NUM_T2)
         shift_amt = 5'h00; // RULE12
      else if (lines == RFE_LINES_256)
         shift_amt = 5'h01; // RULE12
      else if (num > RFE_NUM_T4)
         shift_amt = 5'h01; // RULE11
      else if (num > RFE_NUM_T8)
         shift_amt = 5'h02; // RULE11
      else if (lines == RFE_LINES_1024)
         shift_amt = 5'h03; // RULE12
      else if (num > RFE_NUM_T16)
         shift_amt = 5'h03; // RULE11
      else if (num > RFE_NUM_T32)
         shift_amt = 5'h04; // RULE11
      else
         shift_amt = 5'h05; // RULE11
      scaled = src_val >> shift_amt; // RULE10
   end

   // quadrature stepping: signed delta handles 65535 to 0 wrap as one step
   always_comb
   begin
      delta = scaled - prev_scaled; // RULE15
      next_prev_scaled = prev_scaled;
      next_cnt_pos = cnt_pos;
      next_quad = quad;
      // one count per clock; large jumps are spread over following clocks
      if (delta != 16'h0000)
      begin
         if (delta[15])
         begin
            next_quad = quad - 2'h1;
            next_prev_scaled = prev_scaled - 16'h0001;
            next_cnt_pos = cnt_pos - 16'h0001;
         end
         else
         begin
            next_quad = quad + 2'h1;
            next_prev_scaled = prev_scaled + 16'h0001;
            next_cnt_pos = cnt_pos + 16'h0001;
         end
      end
      // gray order 00,01,11,10 gives four edges per line
      next_enc_a = next_quad[1]; // RULE14
      next_enc_b = next_quad[1] ^ next_quad[0]; // RULE14
   end

   // encoder registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_scaled <= 16'h0000;
         cnt_pos <= 16'h0000;
         quad <= 2'h0;
         enc_a <= 1'b0;
         enc_b <= 1'b0;
      end
      else
      begin
         prev_scaled <= next_prev_scaled;
         cnt_pos <= next_cnt_pos;
         quad <= next_quad;
         enc_a <= next_enc_a;
         enc_b <= next_enc_b;
      end
   end

   // checks; each label line carries the rule it guards, except irq_level_a and ready_pulse_a
   poles_legal_a: assert property ( // RULE2
      @(posedge pclk) disable iff (!presetn)
      poles inside {4'h2, 4'h4, 4'h6, 4'h8})
      else $error("pole count illegal");
   cycles_half_a: assert property ( // RULE1
      @(posedge pclk) disable iff (!presetn)
      ##1 elec_cycles == 3'($past(poles) >> 1))
      else $error("electrical cycles not poles over two");
   no_check_off_a: assert property ( // RULE4
      @(posedge pclk) disable iff (!presetn)
      !wbd_en && !drive_trip |=> !drive_trip)
      else $error("trip while check disabled");
   trip_raise_a: assert property ( // RULE5
      @(posedge pclk) disable iff (!presetn)
      wbd_en && wire_fault |=> drive_trip && stat[RFE_ST_TRIP])
      else $error("break not tripped");
   trip_held_a: assert property ( // RULE5
      @(posedge pclk) disable iff (!presetn)
      drive_trip |=> drive_trip)
      else $error("trip dropped before reset");
   stat_sticky_a: assert property ( // RULE5
      @(posedge pclk) disable iff (!presetn)
      stat[RFE_ST_TRIP] && !(rd && paddr == RFE_OFF_STAT)
      |=> stat[RFE_ST_TRIP])
      else $error("trip status lost without a read");
   src_range_a: assert property ( // RULE9
      @(posedge pclk) disable iff (!presetn)
      src_id[15:8] <= RFE_SRC_MENU_MAX && src_id[7:0] <= RFE_SRC_PAR_MAX)
      else $error("source id out of range");
   unity_scale_a: assert property ( // RULE10
      @(posedge pclk) disable iff (!presetn)
      num > RFE_NUM_T2 |-> scaled == src_val)
      else $error("unity scale not applied");
   floor_10b_a: assert property ( // RULE12
      @(posedge pclk) disable iff (!presetn)
      lines == RFE_LINES_256 && num <= RFE_NUM_T2 |-> shift_amt == 5'h01)
      else $error("10-bit floor wrong");
   floor_12b_a: assert property ( // RULE12
      @(posedge pclk) disable iff (!presetn)
      lines == RFE_LINES_1024 && num <= RFE_NUM_T8 |-> shift_amt == 5'h03)
      else $error("12-bit floor wrong");
   min_14b_a: assert property ( // RULE11
      @(posedge pclk) disable iff (!presetn)
      lines == RFE_LINES_4096 && num <= RFE_NUM_T32 |-> shift_amt == 5'h05)
      else $error("14-bit 1/32 wrong");
   quad_gray_a: assert property ( // RULE14
      @(posedge pclk) disable iff (!presetn)
      ##1 !(enc_a != $past(enc_a) && enc_b != $past(enc_b)))
      else $error("both phases moved");
   wrap_step_a: assert property ( // RULE15
      @(posedge pclk) disable iff (!presetn)
      scaled == 16'h0000 && prev_scaled == 16'hFFFF
      |=> cnt_pos == $past(cnt_pos) + 16'h0001)
      else $error("wrap not a single step");
   irq_level_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq == |(stat & mask))
      else $error("irq not tracking status");
   ready_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held past one cycle");
   // main scenarios
   trip_c: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(drive_trip));
   step_c: cover property (@(posedge pclk) disable iff (!presetn)
      $changed(enc_a) ##1 $changed(enc_b));
   alt_c: cover property (@(posedge pclk) disable iff (!presetn)
      !use_res && delta != 16'h0000);
   irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // rfe_top

/* rfe_pkg.sv */
// rfe_pkg: register map, field layout, reset values and constants for the
// resolver feedback and simulated encoder block.
// assumes a 32-bit apb slave at word-aligned byte offsets.
package rfe_pkg;
   // register byte offsets
   localparam logic [7:0] RFE_OFF_CFG = 8'h00;
   localparam logic [7:0] RFE_OFF_SRC = 8'h04;
   localparam logic [7:0] RFE_OFF_NUM = 8'h08;
   localparam logic [7:0] RFE_OFF_POS = 8'h0C;
   localparam logic [7:0] RFE_OFF_STAT = 8'h10;
   localparam logic [7:0] RFE_OFF_MASK = 8'h14;
   localparam logic [7:0] RFE_OFF_INFO = 8'h18;
   // cfg fields
   localparam int RFE_CFG_POLES_LSB = 0; // 4 bits, pole count
   localparam int RFE_CFG_LINES_LSB = 4; // 2 bits: 0=256 1=1024 2=4096
   localparam int RFE_CFG_WBD_BIT = 8;   // wire break check enable
   // reset values
   localparam logic [3:0] RFE_POLES_RST = 4'h2;
   localparam logic [1:0] RFE_LINES_RST = 2'h2;
   localparam logic RFE_WBD_RST = 1'b1;
   // source id: menu in [15:8], parameter in [7:0]; x.05 of slot menu 16
   localparam logic [15:0] RFE_SRC_RST = 16'h1005;
   localparam logic [7:0] RFE_SRC_MENU_MAX = 8'h15; // 21
   localparam logic [7:0] RFE_SRC_PAR_MAX = 8'h33;  // 51
   // numerator in 1/10000 units
   localparam logic [15:0] RFE_NUM_RST = 16'h2710;  // 1.0000
   localparam logic [15:0] RFE_NUM_MAX = 16'h7530;  // 3.0000
   localparam logic [15:0] RFE_NUM_T32 = 16'h0138;  // 0.0312
   localparam logic [15:0] RFE_NUM_T16 = 16'h0271;  // 0.0625
   localparam logic [15:0] RFE_NUM_T8 = 16'h04E2;   // 0.1250
   localparam logic [15:0] RFE_NUM_T4 = 16'h09C4;   // 0.2500
   localparam logic [15:0] RFE_NUM_T2 = 16'h1388;   // 0.5000
   // line count codes
   localparam logic [1:0] RFE_LINES_256 = 2'h0;
   localparam logic [1:0] RFE_LINES_1024 = 2'h1;
   localparam logic [1:0] RFE_LINES_4096 = 2'h2;
   // status bits
   localparam int RFE_ST_TRIP = 0;
   localparam int RFE_ST_CFGERR = 1;
   localparam int RFE_NEVT = 2;
   // number of selectable source slots in the source table
   localparam int RFE_NSRC = 4;
endpackage : rfe_pkg

/* rfe_src_mem.sv */
// rfe_src_mem: small table of 16-bit rollover source counters, registered
// read port. assumes one writer per entry per clock.
module rfe_src_mem
   import rfe_pkg::*;
#(
   parameter int DEPTH = RFE_NSRC
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write side
   input wire logic [DEPTH-1:0] wr_en,
   input wire logic [16*DEPTH-1:0] wr_data,
   // read side
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [15:0] rd_data
);
   logic [15:0] mem [DEPTH];
   logic [15:0] next_rd_data;

   // selection of the addressed entry
   always_comb
   begin
      next_rd_data = mem[rd_idx];
   end

   // entry storage, one per generate slot
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_ent
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               mem[g] <= 16'h0000;
            else if (wr_en[g])
               mem[g] <= wr_data[16*g +: 16];
         end
      end
   endgenerate

   // read data registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_data <= 16'h0000;
      else
         rd_data <= next_rd_data;
   end
endmodule // rfe_src_mem

/* rfe_partner.sv */
// rfe_partner: resolver position source and quadrature encoder receiver.
// assumes enc_a/enc_b are registered on pclk and step once per clock.
module rfe_partner
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // commands from the bench
   input wire logic [15:0] set_pos,
   input wire logic set_fault,
   // sensor side
   output logic [15:0] res_pos,
   output logic wire_fault,
   // receiver side
   input wire logic enc_a,
   input wire logic enc_b,
   output logic [15:0] rx_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] q_prev;
   logic [1:0] q_now;
   // gray state back to a two-bit count
   assign q_now = {enc_a, enc_a ^ enc_b};
   // sensor values launched on the edge, like a real synchronous source
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         res_pos <= 16'h0000;
         wire_fault <= 1'b0;
         q_prev <= 2'h0;
         rx_cnt <= 16'h0000;
      end
      else
      begin
         res_pos <= set_pos;
         wire_fault <= set_fault;
         q_prev <= q_now;
         // a jump of two counts is illegal quadrature and is dropped
         if (q_now == q_prev + 2'h1)
            rx_cnt <= rx_cnt + 16'h0001;
         else if (q_now == q_prev - 2'h1)
            rx_cnt <= rx_cnt - 16'h0001;
      end
   end
endmodule // rfe_partner

/* test_resolver_feedback_encoder_sim.sv */
// test_resolver_feedback_encoder_sim: apb driven tests of the block.
// assumes rfe_top answers each apb access with one registered pready.
module test_resolver_feedback_encoder_sim;
   import rfe_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [63:0] alt_pos;
   logic [3:0] alt_upd;
   logic [15:0] res_pos, set_pos, rx_cnt;
   logic wire_fault, set_fault, drive_trip, enc_a, enc_b, irq, err;
   logic [2:0] elec_cycles;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [1:0] sl[10] = '{2, 2, 2, 2, 2, 2, 1, 1, 0, 0};
   logic [15:0] sn[10] = '{16'h0138, 16'h0139, 16'h04E2, 16'h09C4,
      16'h1388, 16'h1389, 16'h0000, 16'h09C4, 16'h04E2, 16'h1389};
   int sh[10] = '{5, 4, 3, 2, 1, 0, 3, 2, 1, 0};

   rfe_top #(.NSRC(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .res_pos(res_pos), .wire_fault(wire_fault), .alt_pos(alt_pos),
      .alt_upd(alt_upd), .drive_trip(drive_trip),
      .elec_cycles(elec_cycles), .enc_a(enc_a), .enc_b(enc_b), .irq(irq));
   rfe_partner far_u (.pclk(pclk), .presetn(presetn), .set_pos(set_pos),
      .set_fault(set_fault), .res_pos(res_pos), .wire_fault(wire_fault),
      .enc_a(enc_a), .enc_b(enc_b), .rx_cnt(rx_cnt));

   // 40 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // hang guard, well above the summed settle limits
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; pready, read data and error taken at one rising edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait count assumed; only the hang guard ends a stuck access
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd_v, err);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rd_v, err);
      chk(rd_v, exp);
   endtask

   // wait for the receiver to reach exp, then compare it and the count
   task automatic settle(input logic [15:0] exp, input int lim);
      int n = 0;
      while (rx_cnt !== exp && n < lim)
      begin
         @(negedge pclk);
         n++;
      end
      chk({16'h0, rx_cnt}, {16'h0, exp});
      rd(RFE_OFF_POS, {16'h0, exp});
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      alt_pos = 64'h0;
      alt_upd = 4'h0;
      set_pos = 16'h0000;
      set_fault = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped address
      rd(RFE_OFF_CFG, 32'h0000_0122);
      rd(RFE_OFF_SRC, 32'h0000_1005);
      rd(RFE_OFF_NUM, 32'h0000_2710);
      rd(RFE_OFF_MASK, 32'h0);
      chk({31'h0, err}, 32'h0);
      rd(8'h1C, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test defaults done");
      // pole count to electrical cycles, matched to the motor
      for (int p = 2; p <= 8; p += 2)
      begin
         wr(RFE_OFF_CFG, 32'h0000_0120 | p);
         // elec_cycles is registered one edge after poles
         repeat (2) @(negedge pclk);
         chk({29'h0, elec_cycles}, p / 2);
         rd(RFE_OFF_INFO, p / 2);
      end
      // refused fields raise the config event and the interrupt
      wr(RFE_OFF_MASK, 32'h3);
      wr(RFE_OFF_CFG, 32'h0000_0123);
      rd(RFE_OFF_CFG, 32'h0000_0128);
      wr(RFE_OFF_CFG, 32'h0000_0138);
      rd(RFE_OFF_CFG, 32'h0000_0128);
      repeat (2) @(negedge pclk);
      chk({31'h0, irq}, 32'h1);
      rd(RFE_OFF_STAT, 32'h2);
      rd(RFE_OFF_STAT, 32'h0);
      repeat (2) @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(RFE_OFF_NUM, 32'h0000_7531);
      rd(RFE_OFF_NUM, 32'h0000_2710);
      wr(RFE_OFF_SRC, 32'h0000_1600);
      wr(RFE_OFF_SRC, 32'h0000_1534);
      rd(RFE_OFF_SRC, 32'h0000_1005);
      wr(RFE_OFF_SRC, 32'h0000_1533);
      rd(RFE_OFF_SRC, 32'h0000_1533);
      wr(RFE_OFF_SRC, 32'h0000_1005);
      wr(RFE_OFF_MASK, 32'h0);
      rd(RFE_OFF_STAT, 32'h2);
      $display("test config done");
      // default source reproduced one to one
      set_pos <= 16'h0123;
      settle(16'h0123, 1200);
      // factor quantisation per resolution
      set_pos <= 16'h0400;
      for (int i = 0; i < 10; i++)
      begin
         wr(RFE_OFF_CFG, {23'h0, 1'b1, 2'h0, sl[i], 4'h2});
         wr(RFE_OFF_NUM, {16'h0, sn[i]});
         settle(16'h0400 >> sh[i], 1200);
      end
      $display("test scaling done");
      // wrap is one step and the short way round
      wr(RFE_OFF_CFG, 32'h0000_0122);
      wr(RFE_OFF_NUM, 32'h0000_7530);
      wr(RFE_OFF_NUM, 32'h0000_2710);
      set_pos <= 16'h0002;
      settle(16'h0002, 1200);
      set_pos <= 16'hFFFE;
      settle(16'hFFFE, 12);
      set_pos <= 16'h0000;
      settle(16'h0000, 12);
      // alternate rollover counter as source
      wr(RFE_OFF_SRC, 32'h0000_0000);
      @(posedge pclk);
      alt_pos[15:0] <= 16'h0050;
      alt_upd <= 4'h1;
      @(posedge pclk);
      alt_upd <= 4'h0;
      settle(16'h0050, 1200);
      $display("test encoder done");
      // wire break check off, then on
      wr(RFE_OFF_CFG, 32'h0000_0022);
      set_fault <= 1'b1;
      repeat (5) @(negedge pclk);
      chk({31'h0, drive_trip}, 32'h0);
      rd(RFE_OFF_STAT, 32'h0);
      wr(RFE_OFF_CFG, 32'h0000_0122);
      repeat (2) @(negedge pclk);
      chk({31'h0, drive_trip}, 32'h1);
      rd(RFE_OFF_STAT, 32'h1);
      @(posedge pclk);
      set_fault <= 1'b0;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({31'h0, drive_trip}, 32'h0);
      chk({29'h0, elec_cycles}, 32'h1);
      $display("test wire break done");
      report_and_stop();
   end
endmodule // test_resolver_feedback_encoder_sim
